// file: rtl/lowpower_cal_and_trim_regs.sv
// low-power calibration control and fuse-loaded trim registers
`timescale 1ns/10ps
// What this block does
// - sleep code picks one of eight sleep times
// - sleep code used only autonomous low-power; resets 4
// - wake code picks one of four settle times
// - settle applies in both modes; resets 1
// - select clear: autonomous, timed sleep
// - select set: sleep while trigger high
// - low-power needs background cal; resets off
// - gain trim adjusts all cores
// - reference trim four low bits, rest reserved
// - trims load factory values, stay rewritable
// - one termination trim per input
module lowpower_cal_and_trim_regs #(
	parameter logic [7:0][lp_cal_pkg::CNT_W-1:0] SLEEP_CYCLES = lp_cal_pkg::SLEEP_CYCLES_DEF,
	parameter logic [3:0][lp_cal_pkg::CNT_W-1:0] WAKE_CYCLES = lp_cal_pkg::WAKE_CYCLES_DEF
) (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	output logic o_reg_rvalid,
	input wire logic [7:0] i_fuse_gain,
	input wire logic [3:0] i_fuse_ref,
	input wire logic [7:0] i_fuse_term_a,
	input wire logic [7:0] i_fuse_term_b,
	input wire logic [7:0] i_fuse_term_c,
	input wire logic i_background_cal_enable,
	input wire logic i_cal_trigger,
	input wire logic i_core_offline,
	input wire logic i_cal_done,
	output logic o_core_sleep,
	output logic o_cal_start,
	output logic o_lowpower_active,
	output logic [7:0] o_core_gain_adjust,
	output logic [3:0] o_reference_voltage_adjust,
	output logic [7:0] o_termination_adjust_a,
	output logic [7:0] o_termination_adjust_b,
	output logic [7:0] o_termination_adjust_c
);
	typedef struct packed {
		logic [7:0] lp_ctrl;
		logic [7:0] gain;
		logic [3:0] ref_adj;
		logic [2:0][7:0] term;
		logic [7:0] rdata;
		logic rvalid;
		logic lp_act;
	} regs_s;

	regs_s s_r;
	regs_s s_nxt;

	function automatic logic [7:0] reg_read(input regs_s s, input logic [7:0] a);
		logic [7:0] d;
		d = lp_cal_pkg::UNMAPPED_RD;
		if (a == lp_cal_pkg::OFS_LP_CTRL) begin
			d = s.lp_ctrl;
		end else if (a == lp_cal_pkg::OFS_GAIN) begin
			d = s.gain;
		end else if (a == lp_cal_pkg::OFS_REF) begin
			d = {4'h0, s.ref_adj};
		end else if (a == lp_cal_pkg::OFS_TERM_A) begin
			d = s.term[0];
		end else if (a == lp_cal_pkg::OFS_TERM_B) begin
			d = s.term[1];
		end else if (a == lp_cal_pkg::OFS_TERM_C) begin
			d = s.term[2];
		end
		return d;
	endfunction

	always_comb begin
		s_nxt = s_r;
		s_nxt.rvalid = i_reg_rd;
		if (i_reg_rd) begin
			s_nxt.rdata = reg_read(s_r, i_reg_addr);
		end
		if (i_reg_wr) begin
			// reserved bits are not stored, so they read back as zero
			if (i_reg_addr == lp_cal_pkg::OFS_LP_CTRL) begin
				s_nxt.lp_ctrl = i_reg_wdata & lp_cal_pkg::LP_CTRL_MASK;
			end else if (i_reg_addr == lp_cal_pkg::OFS_GAIN) begin
				s_nxt.gain = i_reg_wdata;
			end else if (i_reg_addr == lp_cal_pkg::OFS_REF) begin
				s_nxt.ref_adj = i_reg_wdata[3:0];
			end else if (i_reg_addr == lp_cal_pkg::OFS_TERM_A) begin
				s_nxt.term[0] = i_reg_wdata;
			end else if (i_reg_addr == lp_cal_pkg::OFS_TERM_B) begin
				s_nxt.term[1] = i_reg_wdata;
			end else if (i_reg_addr == lp_cal_pkg::OFS_TERM_C) begin
				s_nxt.term[2] = i_reg_wdata;
			end
		end
		// low-power enable only counts with background calibration on
		s_nxt.lp_act = s_nxt.lp_ctrl[lp_cal_pkg::LOWPOWER_CAL_ENABLE_BIT] & i_background_cal_enable;
	end

	// synchronous reset, so fuse values can be captured straight from the pins
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			s_r.lp_ctrl <= lp_cal_pkg::LP_CTRL_RST;
			s_r.gain <= i_fuse_gain;
			s_r.ref_adj <= i_fuse_ref;
			s_r.term <= {i_fuse_term_c, i_fuse_term_b, i_fuse_term_a};
			s_r.rdata <= 8'h00;
			s_r.rvalid <= 1'b0;
			s_r.lp_act <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	lp_sleep_seq #(
		.SLEEP_CYCLES(SLEEP_CYCLES),
		.WAKE_CYCLES(WAKE_CYCLES)
	) u_seq (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_lp_active(s_r.lp_act),
		.i_trigger_sleep_select(s_r.lp_ctrl[lp_cal_pkg::TRIG_SEL_BIT]),
		.i_cal_trigger(i_cal_trigger),
		.i_sleep_delay_code(s_r.lp_ctrl[lp_cal_pkg::SLEEP_MSB:lp_cal_pkg::SLEEP_LSB]),
		.i_wake_settle_code(s_r.lp_ctrl[lp_cal_pkg::WAKE_MSB:lp_cal_pkg::WAKE_LSB]),
		.i_core_offline(i_core_offline),
		.i_cal_done(i_cal_done),
		.o_core_sleep(o_core_sleep),
		.o_cal_start(o_cal_start),
		.o_state()
	);

	assign o_reg_rdata = s_r.rdata;
	assign o_reg_rvalid = s_r.rvalid;
	assign o_lowpower_active = s_r.lp_act;
	assign o_core_gain_adjust = s_r.gain;
	assign o_reference_voltage_adjust = s_r.ref_adj;
	assign o_termination_adjust_a = s_r.term[0];
	assign o_termination_adjust_b = s_r.term[1];
	assign o_termination_adjust_c = s_r.term[2];
endmodule

// file: rtl/lp_cal_pkg.sv
// constants for the low-power calibration and trim register block
package lp_cal_pkg;
	// register offsets on the control port
	localparam logic [7:0] OFS_LP_CTRL = 8'h6e;
	localparam logic [7:0] OFS_GAIN = 8'h7a;
	localparam logic [7:0] OFS_REF = 8'h7c;
	localparam logic [7:0] OFS_TERM_A = 8'h7e;
	localparam logic [7:0] OFS_TERM_B = 8'h7f;
	localparam logic [7:0] OFS_TERM_C = 8'h80;

	// lowpower_calibration_control fields
	localparam int SLEEP_LSB = 5;
	localparam int SLEEP_MSB = 7;
	localparam int WAKE_LSB = 3;
	localparam int WAKE_MSB = 4;
	localparam int TRIG_SEL_BIT = 1;
	localparam int LOWPOWER_CAL_ENABLE_BIT = 0;
	localparam logic [7:0] LP_CTRL_RST = 8'h88;
	localparam logic [7:0] LP_CTRL_MASK = 8'hfb;
	localparam logic [7:0] REF_MASK = 8'h0f;
	localparam logic [7:0] UNMAPPED_RD = 8'h00;

	// delays in sample-clock periods, one entry per code, index 0 in the low word
	localparam int CNT_W = 41;
	localparam logic [7:0][CNT_W-1:0] SLEEP_CYCLES_DEF = {
		41'h10000000080, 41'h02000000080, 41'h00400000080, 41'h00080000080,
		41'h00010000080, 41'h00002000080, 41'h00000400080, 41'h00000000480};
	localparam logic [3:0][CNT_W-1:0] WAKE_CYCLES_DEF = {
		41'h00080000080, 41'h00010000080, 41'h00002000080, 41'h00000000480};

	// sequencer states, gray along idle-sleep-wake-cal
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SLEEP = 2'b01,
		ST_WAKE = 2'b11,
		ST_CAL = 2'b10
	} seq_state_e;
endpackage

// file: rtl/lp_sleep_seq.sv
// sleep / wake settling sequencer for the offline converter core
`timescale 1ns/10ps
module lp_sleep_seq #(
	parameter logic [7:0][lp_cal_pkg::CNT_W-1:0] SLEEP_CYCLES = lp_cal_pkg::SLEEP_CYCLES_DEF,
	parameter logic [3:0][lp_cal_pkg::CNT_W-1:0] WAKE_CYCLES = lp_cal_pkg::WAKE_CYCLES_DEF
) (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_lp_active,
	input wire logic i_trigger_sleep_select,
	input wire logic i_cal_trigger,
	input wire logic [2:0] i_sleep_delay_code,
	input wire logic [1:0] i_wake_settle_code,
	input wire logic i_core_offline,
	input wire logic i_cal_done,
	output logic o_core_sleep,
	output logic o_cal_start,
	output logic [1:0] o_state
);
	typedef struct packed {
		lp_cal_pkg::seq_state_e st;
		logic [lp_cal_pkg::CNT_W-1:0] cnt;
		logic sleep;
		logic start;
	} seq_s;

	seq_s s_r;
	seq_s s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.start = 1'b0;
		case (s_r.st)
			lp_cal_pkg::ST_IDLE: begin
				if (i_core_offline) begin
					if (i_lp_active) begin
						// counter restarts on every sleep entry
						s_nxt.st = lp_cal_pkg::ST_SLEEP;
						s_nxt.sleep = 1'b1;
						s_nxt.cnt = SLEEP_CYCLES[i_sleep_delay_code] - 1'b1;
					end else begin
						s_nxt.st = lp_cal_pkg::ST_CAL;
						s_nxt.start = 1'b1;
					end
				end
			end
			lp_cal_pkg::ST_SLEEP: begin
				if (!i_lp_active) begin
					s_nxt.st = lp_cal_pkg::ST_CAL;
					s_nxt.sleep = 1'b0;
					s_nxt.start = 1'b1;
				end else if (i_trigger_sleep_select ? !i_cal_trigger : (s_r.cnt == '0)) begin
					// settle time counted afresh at each wake
					s_nxt.st = lp_cal_pkg::ST_WAKE;
					s_nxt.sleep = 1'b0;
					s_nxt.cnt = WAKE_CYCLES[i_wake_settle_code] - 1'b1;
				end else begin
					s_nxt.cnt = s_r.cnt - 1'b1;
				end
			end
			lp_cal_pkg::ST_WAKE: begin
				if (s_r.cnt == '0 || !i_lp_active) begin
					s_nxt.st = lp_cal_pkg::ST_CAL;
					s_nxt.start = 1'b1;
				end else begin
					s_nxt.cnt = s_r.cnt - 1'b1;
				end
			end
			default: begin
				if (i_cal_done) begin
					s_nxt.st = lp_cal_pkg::ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			s_r <= '{st: lp_cal_pkg::ST_IDLE, cnt: '0, sleep: 1'b0, start: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_core_sleep = s_r.sleep;
	assign o_cal_start = s_r.start;
	assign o_state = s_r.st;
endmodule

// file: test/lowpower_cal_and_trim_regs_bench.sv
// self-checking bench: register access and sleep/wake sequencing
`timescale 1ns/10ps
module lowpower_cal_and_trim_regs_bench;
	// short counts keep the run brief; code n sleeps n+2, wakes n+2
	localparam logic [7:0][40:0] SL = {41'h9, 41'h8, 41'h7, 41'h6, 41'h5, 41'h4, 41'h3, 41'h2};
	localparam logic [3:0][40:0] WK = {41'h5, 41'h4, 41'h3, 41'h2};
	logic [7:0] ad[6] = '{8'h7a, 8'h7c, 8'h7e, 8'h7f, 8'h80, 8'h6e};
	logic [7:0] mk[6] = '{8'hff, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hfb};
	logic [7:0] fz[5];
	logic [7:0] a = 8'h0, d = 8'h0, rdat;
	logic [7:0] tg, ta, tb, tc;
	logic [3:0] tr;
	logic lpa;
	logic clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, bg = 1'h0, trg = 1'h0, off = 1'h0, done = 1'h0, rv, slp, st;
	int n_mismatch = 0, cmp_count = 0, s, w, j;
	lowpower_cal_and_trim_regs #(.SLEEP_CYCLES(SL), .WAKE_CYCLES(WK)) u_lowpower_cal_and_trim_regs (
		.i_core_clk(clk), .i_srst(rst), .i_reg_addr(a), .i_reg_wdata(d), .i_reg_wr(wr), .i_reg_rd(rd),
		.o_reg_rdata(rdat), .o_reg_rvalid(rv), .i_fuse_gain(fz[0]), .i_fuse_ref(fz[1][3:0]),
		.i_fuse_term_a(fz[2]), .i_fuse_term_b(fz[3]), .i_fuse_term_c(fz[4]), .i_background_cal_enable(bg),
		.i_cal_trigger(trg), .i_core_offline(off), .i_cal_done(done), .o_core_sleep(slp), .o_cal_start(st),
		.o_lowpower_active(lpa), .o_core_gain_adjust(tg), .o_reference_voltage_adjust(tr),
		.o_termination_adjust_a(ta), .o_termination_adjust_b(tb), .o_termination_adjust_c(tc));
	always #50 clk = ~clk;
	// trim output that belongs to register index k, reserved ref bits as zero
	function automatic logic [7:0] trim_out(input int k);
		logic [7:0] v;
		v = tc;
		if (k == 0)
			v = tg;
		else if (k == 1)
			v = {4'h0, tr};
		else if (k == 2)
			v = ta;
		else if (k == 3)
			v = tb;
		return v;
	endfunction
	task automatic give_verdict();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [7:0] aa, input logic [7:0] dd);
		@(negedge clk);
		wr = 1'h1;
		a = aa;
		d = dd;
		@(negedge clk);
		wr = 1'h0;
	endtask
	task automatic rreg(input logic [7:0] aa, input logic [7:0] e);
		@(negedge clk);
		rd = 1'h1;
		a = aa;
		@(negedge clk);
		rd = 1'h0;
		chk({7'h0, rv}, 8'h1);
		chk(rdat, e);
	endtask
	// counts sleep cycles, then settle cycles up to the start pulse
	task automatic seq(output int s, output int w);
		@(negedge clk);
		off = 1'h1;
		@(negedge clk);
		off = 1'h0;
		s = 0;
		w = 0;
		while (slp && s < 99) begin
			s++;
			@(negedge clk);
		end
		while (!st && w < 99) begin
			w++;
			@(negedge clk);
		end
		if (s > 98 || w > 98) begin
			n_mismatch++;
			give_verdict();
		end
		done = 1'h1;
		@(negedge clk);
		done = 1'h0;
	endtask
	initial begin
		void'($urandom(85));
		foreach (fz[i])
			fz[i] = $urandom;
		repeat (20) @(negedge clk);
		rst = 1'h0;
		rreg(8'h6e, 8'h88);
		for (int i = 0; i < 5; i++) begin
			rreg(ad[i], fz[i] & mk[i]);
			chk(trim_out(i), fz[i] & mk[i]);
		end
		// twelve random writes across the six registers, each read back
		for (int i = 0; i < 12; i++) begin
			j = $urandom % 6;
			wreg(ad[j], 8'($urandom) & mk[j]);
			rreg(ad[j], d & mk[j]);
			if (j < 5)
				chk(trim_out(j), d & mk[j]);
		end
		wreg(8'h7c, 8'h0f);
		rreg(8'h7c, 8'h0f);
		wreg(8'h01, 8'h5a);
		rreg(8'h01, 8'h00);
		bg = 1'h1;
		// discouraged low codes are still legal and their counts must hold
		for (int i = 0; i < 8; i++) begin
			j = $urandom % 4;
			wreg(8'h6e, {i[2:0], j[1:0], 3'h1});
			chk({7'h0, lpa}, 8'h1);
			seq(s, w);
			chk(8'(s), 8'(SL[i]));
			chk(8'(w), 8'(WK[j]));
		end
		wreg(8'h6e, 8'h8b);
		trg = 1'h1;
		fork
			seq(s, w);
			begin
				repeat (6) @(negedge clk);
				trg = 1'h0;
			end
		join
		chk(8'(s > 4 && s < 7), 8'h1);
		chk(8'(w), 8'(WK[1]));
		bg = 1'h0;
		seq(s, w);
		chk(8'(s + w), 8'h0);
		chk({7'h0, lpa}, 8'h0);
		give_verdict();
	end
endmodule

// file: test/lp_cal_regs_sva.sv
// port assertions for the low-power calibration register block
`timescale 1ns/10ps
module lp_cal_regs_sva (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic o_reg_rvalid,
	input wire logic i_background_cal_enable,
	input wire logic i_core_offline,
	input wire logic o_core_sleep,
	input wire logic o_cal_start,
	input wire logic o_lowpower_active,
	input wire logic [7:0] o_core_gain_adjust
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_srst);
	a_read_answer: assert property (i_reg_rd |=> o_reg_rvalid) else $error("no rvalid");
	a_answer_cause: assert property (!i_reg_rd |=> !o_reg_rvalid) else $error("stray rvalid");
	a_gain_write: assert property (i_reg_wr && i_reg_addr == 8'h7a |=> o_core_gain_adjust == $past(i_reg_wdata))
		else $error("gain not written");
	a_trim_hold: assert property (!i_reg_wr |=> $stable(o_core_gain_adjust)) else $error("gain moved");
	a_lp_needs_bg: assert property (!i_background_cal_enable |=> !o_lowpower_active) else $error("lp on");
	a_sleep_cause: assert property ($rose(o_core_sleep) |-> $past(i_core_offline)) else $error("bad sleep");
	a_wake_settle: assert property ($fell(o_core_sleep) && o_lowpower_active |-> !o_cal_start [*2])
		else $error("no settle");
	a_start_pulse: assert property (o_cal_start |=> !o_cal_start) else $error("long start");
	c_wake: cover property ($fell(o_core_sleep));
	c_direct: cover property (o_cal_start && !o_lowpower_active);
	c_gain: cover property (i_reg_wr && i_reg_addr == 8'h7a);
endmodule
bind lowpower_cal_and_trim_regs lp_cal_regs_sva u_lp_cal_regs_sva (.*);
